// File: hw/pbsa_ctl_end.sv
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module pbsa_ctl_end
    import pbsa_pkg::*;
#(
    parameter int LANES  = PBSA_LANES,
    parameter int BYTE_W = PBSA_BYTE_W,
    parameter int ADDR_W = PBSA_ADDR_W
)(
    // clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // memory pins
    pbsa_if.ctl              BUS
);
    localparam int DW = LANES * BYTE_W;

    // software registers
    logic [ADDR_W-1:0] addr_reg;
    logic [DW-1:0]     wdata_reg;
    logic [1:0]        cfg;
    logic              rdv;
    logic [DW-1:0]     rd_data;
    logic [LANES-1:0]  rd_par;

    // command on the pins
    logic              pend;
    pbsa_op_t          pin_op;
    logic [ADDR_W-1:0] pin_addr;
    logic [LANES-1:0]  pin_mask_n;
    logic [DW-1:0]     pin_wd;
    logic [LANES-1:0]  pin_wp;
    logic              burst_on;
    logic              burst_wr;

    // pipeline mirror of the memory
    logic              p1_valid;
    logic              p1_write;
    logic [DW-1:0]     p1_wd;
    logic [LANES-1:0]  p1_wp;
    logic              p2_read;
    logic              oe_n;
    logic              drv;
    logic [DW-1:0]     drv_dq;
    logic [LANES-1:0]  drv_par;

    // decodes
    wire               acc;
    wire               wr;
    wire               hit;
    wire               cmd_wr;
    wire               stall;
    wire               take;
    wire               take_rw;
    wire               take_adv;
    wire               busy;
    pbsa_op_t          wr_op;

    assign acc    = PSEL & PENABLE;
    assign wr     = acc & PWRITE;
    assign hit    = (PADDR == PBSA_OFF_ADDR) | (PADDR == PBSA_OFF_WDATA)
                  | (PADDR == PBSA_OFF_CMD) | (PADDR == PBSA_OFF_CFG)
                  | (PADDR == PBSA_OFF_STATUS) | (PADDR == PBSA_OFF_RDATA);
    // a command lands only when the pins are free
    assign cmd_wr = wr & (PADDR == PBSA_OFF_CMD) & ~pend;
    assign wr_op  = pbsa_op_t'(PWDATA[PBSA_CMD_OP_LSB +: 2]);
    assign stall  = cfg[PBSA_CFG_STALL_BIT];
    assign take   = pend & ~stall;
    assign take_rw  = take & ((pin_op == PBSA_OP_READ)
                           | (pin_op == PBSA_OP_WRITE));
    assign take_adv = take & (pin_op == PBSA_OP_ADVANCE) & burst_on;
    assign busy   = pend | p1_valid | p2_read | drv;

    // zero wait slave; read mux is from flops only
    assign PREADY  = 1'b1;
    assign PSLVERR = acc & ~hit;
    always_comb begin
        PRDATA = 32'h0;
        case (PADDR)
            PBSA_OFF_ADDR:   PRDATA[ADDR_W-1:0] = addr_reg;
            PBSA_OFF_WDATA:  PRDATA[DW-1:0] = wdata_reg;
            PBSA_OFF_CFG:    PRDATA[1:0] = cfg;
            PBSA_OFF_STATUS: begin
                PRDATA[PBSA_ST_BUSY_BIT]  = busy;
                PRDATA[PBSA_ST_RDV_BIT]   = rdv;
                PRDATA[PBSA_ST_SLEEP_BIT] = cfg[PBSA_CFG_SLEEP_BIT];
                PRDATA[PBSA_ST_PAR_LSB +: LANES] = rd_par;
            end
            PBSA_OFF_RDATA:  PRDATA[DW-1:0] = rd_data;
            default:         PRDATA = 32'h0;
        endcase
    end

    // software register writes
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            addr_reg  <= '0;
            wdata_reg <= '0;
            cfg       <= PBSA_CFG_RESET;
        end else if (wr) begin
            if (PADDR == PBSA_OFF_ADDR) addr_reg <= PWDATA[ADDR_W-1:0];
            if (PADDR == PBSA_OFF_WDATA) wdata_reg <= PWDATA[DW-1:0];
            if (PADDR == PBSA_OFF_CFG) cfg <= PWDATA[1:0];
        end
    end

    // pins hold one command until a qualified edge takes it
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            pend       <= 1'b0;
            pin_op     <= PBSA_OP_DESELECT;
            pin_addr   <= '0;
            pin_mask_n <= '1;
            pin_wd     <= '0;
            pin_wp     <= '0;
        end else if (cmd_wr) begin
            pend       <= 1'b1;
            pin_op     <= wr_op;
            pin_addr   <= addr_reg;
            pin_mask_n <= PWDATA[PBSA_CMD_MASK_LSB +: LANES];
            pin_wd     <= wdata_reg;
            pin_wp     <= PWDATA[PBSA_CMD_PAR_LSB +: LANES];
        end else if (take) begin
            // idle pins mean deselect with load
            pend   <= 1'b0;
            pin_op <= PBSA_OP_DESELECT;
        end
    end

    // pipeline steps only on edges the memory also sees
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            burst_on <= 1'b0;
            burst_wr <= 1'b0;
            p1_valid <= 1'b0;
            p1_write <= 1'b0;
            p1_wd    <= '0;
            p1_wp    <= '0;
            p2_read  <= 1'b0;
            oe_n     <= 1'b1;
            drv      <= 1'b0;
            drv_dq   <= '0;
            drv_par  <= '0;
        end else if (~stall) begin
            // mirror of the latched burst direction
            if (take_rw) begin
                burst_on <= 1'b1;
                burst_wr <= (pin_op == PBSA_OP_WRITE);
            end else if (pin_op == PBSA_OP_DESELECT) begin
                // idle pins deselect the memory too, pending or not
                burst_on <= 1'b0;
            end
            p1_valid <= take_rw | take_adv;
            p1_write <= take_rw ? (pin_op == PBSA_OP_WRITE) : burst_wr;
            p1_wd    <= pin_wd;
            p1_wp    <= pin_wp;
            p2_read  <= p1_valid & ~p1_write;
            // enable low only while read data is due
            // enable high on the same edge this end starts to drive
            oe_n     <= ~(p1_valid & ~p1_write);
            // write data on the bus for the second edge
            drv      <= p1_valid & p1_write;
            drv_dq   <= p1_wd;
            drv_par  <= p1_wp;
        end
    end

    // read capture; a new command clears, capture wins
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            rdv     <= 1'b0;
            rd_data <= '0;
            rd_par  <= '0;
        end else if (~stall && p2_read) begin
            rdv     <= 1'b1;
            rd_data <= BUS.dq;
            rd_par  <= BUS.parity_lines;
        end else if (cmd_wr) begin
            rdv <= 1'b0;
        end
    end

    // pin drive
    // selects all active for read or write
    assign BUS.clock_gate_n     = stall;
    assign BUS.select_1_n       = ~(pin_op == PBSA_OP_READ
                                  || pin_op == PBSA_OP_WRITE);
    assign BUS.select_2         = ~BUS.select_1_n;
    assign BUS.select_3_n       = BUS.select_1_n;
    assign BUS.advance_load     = (pin_op == PBSA_OP_ADVANCE);
    assign BUS.write_n          = (pin_op != PBSA_OP_WRITE);
    assign BUS.addr             = pin_addr;
    assign BUS.byte_lane_mask_n = pin_mask_n;
    assign BUS.out_en_n         = oe_n;
    assign BUS.sleep_request    = cfg[PBSA_CFG_SLEEP_BIT];
    assign BUS.ctl_oe           = drv;
    assign BUS.ctl_dq_o         = drv_dq;
    assign BUS.ctl_par_o        = drv_par;
endmodule
`default_nettype wire

// File: hw/pbsa_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pbsa_if
    import pbsa_pkg::*;
#(
    parameter int LANES  = PBSA_LANES,
    parameter int BYTE_W = PBSA_BYTE_W,
    parameter int ADDR_W = PBSA_ADDR_W
);
    localparam int DW = LANES * BYTE_W;

    // command pins, driven by the controller
    logic              clock_gate_n;
    logic              select_1_n;
    logic              select_2;
    logic              select_3_n;
    logic              advance_load;
    logic              write_n;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  byte_lane_mask_n;
    logic              out_en_n;
    logic              sleep_request;

    // shared data and parity, one driver set per end
    logic [DW-1:0]     mem_dq_o;
    logic [LANES-1:0]  mem_par_o;
    logic              mem_oe;
    logic [DW-1:0]     ctl_dq_o;
    logic [LANES-1:0]  ctl_par_o;
    logic              ctl_oe;
    logic [DW-1:0]     dq;
    logic [LANES-1:0]  parity_lines;

    // wire level; an undriven bus reads as zero
    assign dq = mem_oe ? mem_dq_o : (ctl_oe ? ctl_dq_o : '0);
    assign parity_lines = mem_oe ? mem_par_o : (ctl_oe ? ctl_par_o : '0);

    modport mem (
        input  clock_gate_n, select_1_n, select_2, select_3_n,
        input  advance_load, write_n, addr, byte_lane_mask_n,
        input  out_en_n, sleep_request, dq, parity_lines,
        output mem_dq_o, mem_par_o, mem_oe
    );

    modport ctl (
        output clock_gate_n, select_1_n, select_2, select_3_n,
        output advance_load, write_n, addr, byte_lane_mask_n,
        output out_en_n, sleep_request,
        input  dq, parity_lines,
        output ctl_dq_o, ctl_par_o, ctl_oe
    );
endinterface
`default_nettype wire

// File: hw/pbsa_mem_end.sv
// How it works
// - clock gate high freezes burst, pipeline and output state unless in sleep; the synchronisers keep running
// - read starts: selected, write high, load
// - read data driven one edge after command
// - output enable low needed to drive
// - new command accepted every cycle
// - deselect tristates after the next edge
// - burst counter serves four beats
// - strap picks linear or interleaved order
// - counter uses two low bits, wraps
// - advance high increments, ignores selects
// - direction latched at burst start
// - write starts: selected, write low, load
// - edge after write: outputs tristated
// - write data latched two edges later
// - only masked-in lanes and parity written
// - controller never drives over device
// - controller loads after deselect
// - async sleep input, data preserved
// - interleaved beats xor beat index
// - linear beats add beat index
// - reset leaves device deselected, tristated
// - first clock after deselect tristated
`timescale 1ns/10ps
`default_nettype none
module pbsa_mem_end
    import pbsa_pkg::*;
#(
    parameter int LANES  = PBSA_LANES,
    parameter int BYTE_W = PBSA_BYTE_W,
    parameter int ADDR_W = PBSA_ADDR_W
)(
    // clock and reset
    input  wire logic CLOCK,
    input  wire logic RST,
    // static strap and sleep status
    input  wire logic BURST_ORDER,
    output logic      SLEEP_ACTIVE,
    // memory pins
    pbsa_if.mem       BUS
);
    localparam int DW    = LANES * BYTE_W;
    localparam int DEPTH = 1 << ADDR_W;

    // synchronisers for the asynchronous sleep pin and the strap
    logic              sleep_meta;
    logic              sleep_s;
    logic              order_meta;
    logic              order_s;

    // burst state
    pbsa_burst_t       state;
    pbsa_burst_t       next_state;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] next_base;
    logic [1:0]        beat;
    logic [1:0]        next_beat;
    logic              cmd_valid;

    // pipeline stages
    logic              s1_valid;
    logic              s1_write;
    logic [ADDR_W-1:0] s1_addr;
    logic [LANES-1:0]  s1_mask_n;
    logic              s2_valid;
    logic              s2_write;
    logic [ADDR_W-1:0] s2_addr;
    logic [LANES-1:0]  s2_mask_n;

    // output register
    logic              drive;
    logic [DW-1:0]     rd_dq;
    logic [LANES-1:0]  rd_par;
    logic [DW-1:0]     next_rd_dq;
    logic [LANES-1:0]  next_rd_par;

    // decodes
    wire               qualified;
    wire               selected;
    wire               load;
    wire [1:0]         low_bits;
    wire [ADDR_W-1:0]  cmd_addr;
    wire               s1_is_read;
    wire               s2_is_write;

    assign qualified = ~BUS.clock_gate_n;
    assign selected  = ~BUS.select_1_n & BUS.select_2 & ~BUS.select_3_n;
    assign load      = ~BUS.advance_load;

    // only low two bits step, sum wraps in two bits
    assign low_bits = (order_s == PBSA_ORDER_INTERLEAVED)
                    ? (next_base[1:0] ^ next_beat)
                    : 2'(next_base[1:0] + next_beat);
    assign cmd_addr = {next_base[ADDR_W-1:2], low_bits};

    assign s1_is_read  = s1_valid & ~s1_write;
    assign s2_is_write = s2_valid & s2_write;

    // sleep and strap sync, two flops each
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            sleep_meta <= 1'b0;
            sleep_s    <= 1'b0;
            order_meta <= 1'b0;
            order_s    <= 1'b0;
        end else begin
            sleep_meta <= BUS.sleep_request;
            sleep_s    <= sleep_meta;
            order_meta <= BURST_ORDER;
            order_s    <= order_meta;
        end
    end

    // command decode for the coming qualified edge
    always_comb begin
        next_state = state;
        next_base  = base;
        next_beat  = beat;
        cmd_valid  = 1'b0;
        if (load) begin
            if (selected) begin
                next_state = BUS.write_n ? PBSA_BURST_READ
                                         : PBSA_BURST_WRITE;
                next_base  = BUS.addr;
                next_beat  = 2'h0;
                cmd_valid  = 1'b1;
            end else begin
                next_state = PBSA_BURST_IDLE;
            end
        end else if (state != PBSA_BURST_IDLE) begin
            // advance, selects and write strobe ignored
            // one address serves the following beats
            next_beat = 2'(beat + 2'h1);
            cmd_valid = 1'b1;
        end
    end

    // per lane storage, byte plus its parity bit
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [BYTE_W:0] lane_mem [DEPTH];
            wire             wr_lane;
            wire             fwd;
            wire [BYTE_W:0]  wr_word;
            wire [BYTE_W:0]  rd_word;

            assign wr_lane = qualified & ~sleep_s & s2_is_write
                           & ~s2_mask_n[g];
            assign wr_word = {BUS.parity_lines[g],
                              BUS.dq[g*BYTE_W +: BYTE_W]};
            // forward a write landing on the same edge as the read
            assign fwd     = wr_lane & (s2_addr == s1_addr);
            assign rd_word = fwd ? wr_word : lane_mem[s1_addr];
            assign next_rd_dq[g*BYTE_W +: BYTE_W] = rd_word[BYTE_W-1:0];
            assign next_rd_par[g] = rd_word[BYTE_W];

            // write data latched at second edge
            always_ff @(posedge CLOCK) begin
                if (wr_lane) begin
                    lane_mem[s2_addr] <= wr_word;
                end
            end
        end
    endgenerate

    // burst state, pipeline and output register
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state     <= PBSA_BURST_IDLE;
            base      <= '0;
            beat      <= 2'h0;
            s1_valid  <= 1'b0;
            s1_write  <= 1'b0;
            s1_addr   <= '0;
            s1_mask_n <= '1;
            s2_valid  <= 1'b0;
            s2_write  <= 1'b0;
            s2_addr   <= '0;
            s2_mask_n <= '1;
            drive     <= 1'b0;
            rd_dq     <= '0;
            rd_par    <= '0;
        end else if (sleep_s) begin
            state    <= PBSA_BURST_IDLE;
            s1_valid <= 1'b0;
            s2_valid <= 1'b0;
            drive    <= 1'b0;
        end else if (qualified) begin
            // a command is taken on every qualified edge
            state     <= next_state;
            base      <= next_base;
            beat      <= next_beat;
            s1_valid  <= cmd_valid;
            s1_write  <= (next_state == PBSA_BURST_WRITE);
            s1_addr   <= cmd_addr;
            s1_mask_n <= BUS.byte_lane_mask_n;
            // second stage keeps write masks aligned
            s2_valid  <= s1_valid;
            s2_write  <= s1_write;
            s2_addr   <= s1_addr;
            s2_mask_n <= s1_mask_n;
            // data registered one edge after the read
            // deselect shows after the next edge
            // first cycle after deselect stays off
            drive     <= s1_is_read;
            if (s1_is_read) begin
                rd_dq  <= next_rd_dq;
                rd_par <= next_rd_par;
            end
        end
    end

    // output enable gates the registered drive
    // bus is free whenever this end is not driving
    assign BUS.mem_oe    = drive & ~BUS.out_en_n & ~sleep_s;
    assign BUS.mem_dq_o  = rd_dq;
    assign BUS.mem_par_o = rd_par;
    assign SLEEP_ACTIVE  = sleep_s;
endmodule
`default_nettype wire

// File: hw/pbsa_pkg.sv
`default_nettype none
package pbsa_pkg;
    // memory shape
    localparam int PBSA_LANES   = 4;
    localparam int PBSA_BYTE_W  = 8;
    localparam int PBSA_ADDR_W  = 10;
    localparam int PBSA_BEAT_W  = 2;

    // burst order strap levels
    localparam logic PBSA_ORDER_LINEAR      = 1'b0;
    localparam logic PBSA_ORDER_INTERLEAVED = 1'b1;

    // controller register offsets on the apb side
    localparam logic [7:0] PBSA_OFF_ADDR   = 8'h00;
    localparam logic [7:0] PBSA_OFF_WDATA  = 8'h04;
    localparam logic [7:0] PBSA_OFF_CMD    = 8'h08;
    localparam logic [7:0] PBSA_OFF_CFG    = 8'h0C;
    localparam logic [7:0] PBSA_OFF_STATUS = 8'h10;
    localparam logic [7:0] PBSA_OFF_RDATA  = 8'h14;

    // field positions
    localparam int PBSA_CMD_OP_LSB    = 0;
    localparam int PBSA_CMD_MASK_LSB  = 4;
    localparam int PBSA_CMD_PAR_LSB   = 8;
    localparam int PBSA_CFG_STALL_BIT = 0;
    localparam int PBSA_CFG_SLEEP_BIT = 1;
    localparam int PBSA_ST_BUSY_BIT   = 0;
    localparam int PBSA_ST_RDV_BIT    = 1;
    localparam int PBSA_ST_SLEEP_BIT  = 2;
    localparam int PBSA_ST_PAR_LSB    = 8;

    // reset values
    localparam logic [1:0] PBSA_CFG_RESET = 2'h0;

    typedef enum logic [1:0] {
        PBSA_OP_DESELECT = 2'b00,
        PBSA_OP_READ     = 2'b01,
        PBSA_OP_WRITE    = 2'b10,
        PBSA_OP_ADVANCE  = 2'b11
    } pbsa_op_t;

    typedef enum logic [1:0] {
        PBSA_BURST_IDLE  = 2'b00,
        PBSA_BURST_READ  = 2'b01,
        PBSA_BURST_WRITE = 2'b10
    } pbsa_burst_t;
endpackage
`default_nettype wire

// File: verification/pbsa_properties.sv
`timescale 1ns/10ps
`default_nettype none
module pbsa_properties
    import pbsa_pkg::*;
(
    // clock and reset
    input wire logic                                CLOCK,
    input wire logic                                RST,
    // command pins
    input wire logic                                clock_gate_n,
    input wire logic                                select_1_n,
    input wire logic                                select_2,
    input wire logic                                select_3_n,
    input wire logic                                advance_load,
    input wire logic                                write_n,
    input wire logic                                out_en_n,
    input wire logic                                sleep_request,
    // drivers of the shared lines
    input wire logic                                mem_oe,
    input wire logic                                ctl_oe,
    input wire logic [PBSA_LANES*PBSA_BYTE_W-1:0]   mem_dq_o,
    input wire logic [PBSA_LANES-1:0]               mem_par_o
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);

    // commands taken at an edge; sleep edges never count
    wire go      = !clock_gate_n && !sleep_request && !advance_load;
    wire sel_all = !select_1_n && select_2 && !select_3_n;
    wire rd_take = go && sel_all && write_n;
    wire wr_take = go && sel_all && !write_n;
    wire ds_take = go && !sel_all;

    a_read_drive: assert property (
        rd_take ##1 !clock_gate_n |=> mem_oe == !out_en_n)
        else $error("read data not driven one edge after command");
    a_write_tristate: assert property (
        wr_take ##1 !clock_gate_n |=> !mem_oe)
        else $error("memory drives during write data phase");
    a_write_data_on: assert property (
        wr_take ##1 !clock_gate_n |=> ctl_oe)
        else $error("write data not driven for second edge");
    a_deselect_off: assert property (
        ds_take ##1 !clock_gate_n |=> !mem_oe)
        else $error("outputs live after deselect");
    a_resume_off: assert property (
        ds_take ##1 (rd_take || wr_take) |=> !mem_oe)
        else $error("outputs live in first clock after deselect");
    a_stall_holds: assert property (
        clock_gate_n |=> $stable(mem_dq_o) && $stable(mem_par_o))
        else $error("output register moved on stalled edge");
    a_no_fight: assert property (
        !(mem_oe && ctl_oe))
        else $error("both ends drive the data lines");
    a_reset_quiet: assert property (
        $past(RST) |-> !mem_oe && !ctl_oe)
        else $error("data lines driven out of reset");
    a_sleep_off: assert property (
        sleep_request [*3] |-> !mem_oe)
        else $error("outputs live in sleep");
endmodule
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import pbsa_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        order = 1'b0;
    logic        pready, pslverr, err, sleep_act;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [9:0]  a, b;
    logic [35:0] m1 [1024];
    logic [35:0] m2 [1024];
    logic [35:0] bd [4];
    logic [3:0]  bm [4];
    integer      seed = 59242;
    integer      miscompares = 0;
    integer      n_tests = 0;

    pbsa_if bus1 ();
    pbsa_if bus2 ();

    // free running clock
    always #4 clock = ~clock;

    // controller and memory joined, plus a bench-driven memory
    pbsa_ctl_end pbsa_ctl_end_inst (.CLOCK(clock), .RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .BUS(bus1.ctl));
    pbsa_mem_end pbsa_mem_end_inst (.CLOCK(clock), .RST(rst),
        .BURST_ORDER(order), .SLEEP_ACTIVE(sleep_act), .BUS(bus1.mem));
    pbsa_mem_end pbsa_mem_end_inst2 (.CLOCK(clock), .RST(rst),
        .BURST_ORDER(order), .SLEEP_ACTIVE(), .BUS(bus2.mem));
    pbsa_properties pbsa_properties_inst (.CLOCK(clock), .RST(rst),
        .clock_gate_n(bus1.clock_gate_n), .select_1_n(bus1.select_1_n),
        .select_2(bus1.select_2), .select_3_n(bus1.select_3_n),
        .advance_load(bus1.advance_load), .write_n(bus1.write_n),
        .out_en_n(bus1.out_en_n), .sleep_request(bus1.sleep_request),
        .mem_oe(bus1.mem_oe), .ctl_oe(bus1.ctl_oe),
        .mem_dq_o(bus1.mem_dq_o), .mem_par_o(bus1.mem_par_o));

    task automatic complete_run;
        if (miscompares == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [36:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; request held until pready seen high
    task automatic apb(input logic wr, input logic [7:0] ad,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [35:0] rnd();
        return {4'($random(seed)), 32'($random(seed))};
    endfunction

    // byte lanes whose mask is low take the new byte and parity
    function automatic logic [35:0] merge(input logic [35:0] o, n,
                                          input logic [3:0] mk);
        merge = o;
        for (int i = 0; i < 4; i++) begin
            if (!mk[i]) begin
                merge[8*i+:8] = n[8*i+:8];
                merge[32+i] = n[32+i];
            end
        end
    endfunction

    function automatic logic [9:0] beat(input logic [9:0] s, input int k);
        return {s[9:2], order ? s[1:0] ^ k[1:0] : s[1:0] + k[1:0]};
    endfunction

    task automatic mwrite(input logic [3:0] mk, input logic [35:0] d);
        apb(1'b1, PBSA_OFF_ADDR, {22'h0, a});
        apb(1'b1, PBSA_OFF_WDATA, d[31:0]);
        apb(1'b1, PBSA_OFF_CMD, {20'h0, d[35:32], mk, 2'h0, PBSA_OP_WRITE});
        m1[a] = merge(m1[a], d, mk);
    endtask

    // read lands in the data register; poll valid with a bound
    task automatic mread;
        logic [3:0] p;
        apb(1'b1, PBSA_OFF_ADDR, {22'h0, a});
        apb(1'b1, PBSA_OFF_CMD, {30'h0, PBSA_OP_READ});
        apb(1'b0, PBSA_OFF_STATUS, 32'h0);
        for (int i = 0; i < 8 && q[PBSA_ST_RDV_BIT] !== 1'b1; i++)
            apb(1'b0, PBSA_OFF_STATUS, 32'h0);
        p = q[PBSA_ST_PAR_LSB+:4];
        apb(1'b0, PBSA_OFF_RDATA, 32'h0);
        chk("read word", {1'b0, m1[a]}, {1'b0, p, q});
    endtask

    task automatic pins(input logic s, adv, wn, input logic [9:0] ad,
                        input logic [3:0] mk);
        bus2.select_1_n <= !s;
        bus2.select_2 <= s;
        bus2.select_3_n <= !s;
        bus2.advance_load <= adv;
        bus2.write_n <= wn;
        bus2.addr <= ad;
        bus2.byte_lane_mask_n <= mk;
    endtask

    // four-beat burst; advances carry junk selects, direction, address
    task automatic burst(input logic w);
        for (int c = 0; c < 8; c++) begin
            @(posedge clock);
            if (c == 0) pins(1'b1, 1'b0, !w, b, bm[0]);
            else if (c < 4) pins(1'b0, 1'b1, w, ~b, bm[c]);
            else pins(1'b0, 1'b0, 1'b1, b, 4'hF);
            bus2.ctl_oe <= w && c >= 2 && c < 6;
            bus2.ctl_dq_o <= bd[(c+2)%4][31:0];
            bus2.ctl_par_o <= bd[(c+2)%4][35:32];
            #1;
            if (c < 2 || c > 5 || w)
                chk("mem drive", 37'h0, {36'h0, bus2.mem_oe});
            else
                chk("burst beat", {1'b1, m2[beat(b, c-2)]}, {bus2.mem_oe,
                    bus2.parity_lines, bus2.dq});
        end
        for (int k = 0; k < 4 && w; k++)
            m2[beat(b, k)] = merge(m2[beat(b, k)], bd[k], bm[k]);
    endtask

    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #200000;
        miscompares++;
        complete_run;
    end

    // main sequence
    initial begin
        bus2.clock_gate_n = 1'b0;
        bus2.out_en_n = 1'b0;
        bus2.sleep_request = 1'b0;
        bus2.ctl_oe = 1'b0;
        pins(1'b0, 1'b0, 1'b1, 10'h0, 4'hF);
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        apb(1'b0, PBSA_OFF_CFG, 32'h0);
        chk("cfg reset", {35'h0, PBSA_CFG_RESET}, {5'h0, q});
        apb(1'b0, 8'h3C, 32'h0);
        chk("unmapped", 37'h100000000, {4'h0, err, q});
        for (int j = 0; j < 6; j++) begin
            a = 10'($random(seed));
            mwrite(4'h0, rnd());
            mwrite(4'($random(seed)), rnd());
            mread;
        end
        // stall with a read pending; it must wait on the pins
        apb(1'b1, PBSA_OFF_CFG, 32'h1);
        apb(1'b1, PBSA_OFF_CMD, {30'h0, PBSA_OP_READ});
        repeat (4) @(posedge clock);
        apb(1'b0, PBSA_OFF_STATUS, 32'h0);
        chk("stalled status", 37'h1, {35'h0, q[1:0]});
        // unstall first so the read ends before sleep
        apb(1'b1, PBSA_OFF_CFG, 32'h0);
        apb(1'b1, PBSA_OFF_CFG, 32'h2);
        repeat (4) @(posedge clock);
        chk("sleep", 37'h1, {36'h0, sleep_act});
        apb(1'b1, PBSA_OFF_CFG, 32'h0);
        repeat (4) @(posedge clock);
        mread;
        // advance with no open burst acts as a further deselect
        apb(1'b1, PBSA_OFF_CMD, {30'h0, PBSA_OP_ADVANCE});
        repeat (4) @(posedge clock);
        apb(1'b0, PBSA_OFF_STATUS, 32'h0);
        chk("idle advance", 37'h0, {35'h0, q[1:0]});
        for (int o = 0; o < 2; o++) begin
            order <= o[0];
            repeat (3) @(posedge clock);
            b = 10'($random(seed));
            for (int f = 0; f < 2; f++) begin
                for (int k = 0; k < 4; k++) begin
                    bd[k] = rnd();
                    bm[k] = f ? 4'($random(seed)) : 4'h0;
                end
                burst(1'b1);
            end
            burst(1'b0);
        end
        complete_run;
    end
endmodule
`default_nettype wire
